// ==== rtl/pao_port_override.sv ====
`timescale 1ns/1ns
// Summary of operation
// RULE1: Asserted override enable selects override value, else normal port register path.
// RULE2: Async timer2 with external clock: C7 pull-up off, input, buffer follows async.
// RULE3: Async timer2: C6 pull-up off, input; buffer on with external clock or async.
// RULE4: Scan enabled: C5 pull-up on, input, buffer on, feeds scan data input.
// RULE5: Scan enabled: C4 pull-up on, drives scan data out only while shifting.
// RULE6: Scan enabled: C3 pull-up on, input, buffer on, feeds scan mode select.
// RULE7: Scan enabled: C2 pull-up on, input, buffer on, feeds scan clock.
// RULE8: Port C pins are pin-change sources 8-15; mask with group 2 forces buffer.
// RULE9: Two-wire enabled: C1 direction value 0, data output, latch-gated pull-up.
// RULE10: Two-wire enabled: C0 direction value 0, clock output, latch-gated pull-up, buffer not overridden.
// RULE11: Port C analog taps: C7, C6, C5, C3 and C2 to oscillator and scan.
// RULE12: Clock-output fuse forces B1 direction and drives it with the I/O clock.
// RULE13: Compare 0A enabled drives B3 value; B0-B3 never override pull-ups.
// RULE14: B0-B3 feed group 1 sources, irq2, counter clocks; irq2 enable forces B2 buffer.
// RULE15: B4-B7 feed SPI select, slave in, master in, clock and pin-change sources.
// RULE16: SPI slave forces select, slave in and clock to input; pull-ups follow latch.
module pao_port_override
  import pao_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Port registers
  input wire logic [PORT_W-1:0] latchB,
  input wire logic [PORT_W-1:0] latchC,
  input wire logic [PORT_W-1:0] dirRegB,
  input wire logic [PORT_W-1:0] dirRegC,
  input wire logic global_pull_off,
  input wire logic sleepInputOff,
  // Pads
  input wire logic [PORT_W-1:0] padInB,
  input wire logic [PORT_W-1:0] padInC,
  output pao_pad_s padB,
  output pao_pad_s padC,
  // Timer oscillator and clock output
  input wire logic timer2_async_sel,
  input wire logic ext_osc_clock_sel,
  input wire logic sysclk_out_fuse,
  input wire logic ioClkLevel,
  // Scan port
  input wire logic scan_port_enable,
  input wire logic scan_shift_instr,
  input wire logic scan_shift_datareg,
  input wire logic scanDataOut,
  // Two-wire bus
  input wire logic two_wire_enable,
  input wire logic twDataOut,
  input wire logic twClockOut,
  // Compare output, SPI, interrupts
  input wire logic cmp0a_drive_en,
  input wire logic cmp0a_wave,
  input wire logic spiEnable,
  input wire logic spiMaster,
  input wire logic extIrq2Enable,
  input wire logic pinchg_group1_en,
  input wire logic pinchg_group2_en,
  input wire logic [PIN_CNT-1:0] pinchgMask,
  // Routed inputs
  output pao_periph_s periphIn,
  output pao_analog_s analog_path
);

  pao_state_s state_q;
  pao_state_s state_d;
  pao_ovr_s ovr [PIN_CNT];
  logic [PIN_CNT-1:0] latchAll;
  logic [PIN_CNT-1:0] dirAll;
  logic [PIN_CNT-1:0] pullAll;
  logic [PIN_CNT-1:0] driveAll;
  logic [PIN_CNT-1:0] outAll;
  logic [PIN_CNT-1:0] inbufAll;
  logic [PIN_CNT-1:0] pin_sense_value;
  logic [PIN_CNT-1:0] pcForce;
  logic spiSlave;
  logic scanShift;

  assign latchAll = {latchC, latchB};
  assign dirAll = {dirRegC, dirRegB};
  assign spiSlave = spiEnable & ~spiMaster;
  assign scanShift = scan_shift_instr | scan_shift_datareg;
  assign pcForce[PC_BASE-1:0] = pinchgMask[PC_BASE-1:0] & {PORT_W{pinchg_group1_en}};
  assign pcForce[PIN_CNT-1:PC_BASE] = pinchgMask[PIN_CNT-1:PC_BASE] & {PORT_W{pinchg_group2_en}}; // RULE8

  // Per-pin override table
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      ovr[i] = '0;
      ovr[i].inbuf_override_en = pcForce[i];
      ovr[i].inbuf_override_val = 1'b1;
    end
    // Port B low half: pull-ups never overridden
    ovr[PB_CLK_OUT].dir_override_en = sysclk_out_fuse; // RULE12
    ovr[PB_CLK_OUT].dir_override_val = sysclk_out_fuse;
    ovr[PB_CLK_OUT].outval_override_en = sysclk_out_fuse;
    ovr[PB_CLK_OUT].outval_override_val = ioClkLevel;
    ovr[PB_IRQ2].inbuf_override_en = extIrq2Enable | pcForce[PB_IRQ2]; // RULE14
    ovr[PB_CMP0A].outval_override_en = cmp0a_drive_en; // RULE13
    ovr[PB_CMP0A].outval_override_val = cmp0a_wave;
    // SPI inputs: master input pin is forced only in master mode
    for (int i = PB_SPI_SEL; i <= PB_SPI_CLK; i++) begin
      ovr[i].dir_override_en = (i == PB_SPI_MST_IN) ? (spiEnable & spiMaster) : spiSlave; // RULE16
      ovr[i].pullup_override_en = ovr[i].dir_override_en;
      ovr[i].pullup_override_val = latchAll[i] & ~global_pull_off;
    end
    // Timer oscillator pins
    ovr[PC_BASE+PC_XTAL_OUT].pullup_override_en = timer2_async_sel & ext_osc_clock_sel; // RULE2
    ovr[PC_BASE+PC_XTAL_OUT].dir_override_en = timer2_async_sel & ext_osc_clock_sel;
    ovr[PC_BASE+PC_XTAL_OUT].inbuf_override_en = (timer2_async_sel & ext_osc_clock_sel) | pcForce[PC_BASE+PC_XTAL_OUT];
    ovr[PC_BASE+PC_XTAL_OUT].inbuf_override_val = timer2_async_sel | pcForce[PC_BASE+PC_XTAL_OUT];
    ovr[PC_BASE+PC_XTAL_IN].pullup_override_en = timer2_async_sel; // RULE3
    ovr[PC_BASE+PC_XTAL_IN].dir_override_en = timer2_async_sel;
    ovr[PC_BASE+PC_XTAL_IN].inbuf_override_en = timer2_async_sel | pcForce[PC_BASE+PC_XTAL_IN];
    ovr[PC_BASE+PC_XTAL_IN].inbuf_override_val = ext_osc_clock_sel | timer2_async_sel | pcForce[PC_BASE+PC_XTAL_IN];
    // Scan pins: pulled up, buffer held on, inputs except C4 while shifting
    for (int i = PC_BASE + PC_SCAN_CLK; i <= PC_BASE + PC_SCAN_DIN; i++) begin
      ovr[i].pullup_override_en = scan_port_enable; // RULE4 RULE6 RULE7
      ovr[i].pullup_override_val = 1'b1;
      ovr[i].dir_override_en = scan_port_enable;
      ovr[i].inbuf_override_en = scan_port_enable | pcForce[i];
      ovr[i].inbuf_override_val = scan_port_enable | pcForce[i];
    end
    ovr[PC_BASE+PC_SCAN_DOUT].dir_override_val = scanShift; // RULE5
    ovr[PC_BASE+PC_SCAN_DOUT].outval_override_en = scan_port_enable;
    ovr[PC_BASE+PC_SCAN_DOUT].outval_override_val = scanDataOut;
    // Two-wire pins: direction value 0, the bus drives low through the value path
    ovr[PC_BASE+PC_TW_DATA].pullup_override_en = two_wire_enable; // RULE9
    ovr[PC_BASE+PC_TW_DATA].pullup_override_val = latchAll[PC_BASE+PC_TW_DATA] & ~global_pull_off;
    ovr[PC_BASE+PC_TW_DATA].dir_override_en = two_wire_enable;
    ovr[PC_BASE+PC_TW_DATA].outval_override_en = two_wire_enable;
    ovr[PC_BASE+PC_TW_DATA].outval_override_val = twDataOut;
    ovr[PC_BASE+PC_TW_CLK].pullup_override_en = two_wire_enable; // RULE10
    ovr[PC_BASE+PC_TW_CLK].pullup_override_val = latchAll[PC_BASE+PC_TW_CLK] & ~global_pull_off;
    ovr[PC_BASE+PC_TW_CLK].dir_override_en = two_wire_enable;
    ovr[PC_BASE+PC_TW_CLK].outval_override_en = two_wire_enable;
    ovr[PC_BASE+PC_TW_CLK].outval_override_val = twClockOut;
  end

  // Override versus normal port path, one pin per iteration
  for (genvar g = 0; g < PIN_CNT; g++) begin : gPin
    assign driveAll[g] = ovr[g].dir_override_en ? ovr[g].dir_override_val : dirAll[g]; // RULE1
    assign outAll[g] = ovr[g].outval_override_en ? ovr[g].outval_override_val : latchAll[g];
    assign pullAll[g] = ovr[g].pullup_override_en ? ovr[g].pullup_override_val
                                                  : (latchAll[g] & ~dirAll[g] & ~global_pull_off);
    assign inbufAll[g] = ovr[g].inbuf_override_en ? ovr[g].inbuf_override_val : ~sleepInputOff;
  end

  assign padB = '{padOut: outAll[PC_BASE-1:0], padOen_n: ~driveAll[PC_BASE-1:0],
                  pullEn: pullAll[PC_BASE-1:0], inbufEn: inbufAll[PC_BASE-1:0]};
  assign padC = '{padOut: outAll[PIN_CNT-1:PC_BASE], padOen_n: ~driveAll[PIN_CNT-1:PC_BASE],
                  pullEn: pullAll[PIN_CNT-1:PC_BASE], inbufEn: inbufAll[PIN_CNT-1:PC_BASE]};

  // Three-stage pin synchroniser; a level counts once stages two and three agree
  always_comb begin
    state_d = state_q;
    state_d.sync1 = {padInC, padInB};
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    for (int i = 0; i < PIN_CNT; i++) begin
      if (state_q.sync2[i] == state_q.sync3[i]) begin
        state_d.settled[i] = state_q.sync3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{sync1: {SYNC_RST, SYNC_RST}, sync2: {SYNC_RST, SYNC_RST},
                   sync3: {SYNC_RST, SYNC_RST}, settled: {SYNC_RST, SYNC_RST}};
    end else begin
      state_q <= state_d;
    end
  end

  // A disabled buffer reads as low, so a floating pin cannot toggle a peripheral
  assign pin_sense_value = state_q.settled & inbufAll;

  assign periphIn.counter0ExtClock = pin_sense_value[PB_CNT0_CLK]; // RULE14
  assign periphIn.counter1ExtClock = pin_sense_value[PB_CLK_OUT];
  assign periphIn.extIrq2Pin = pin_sense_value[PB_IRQ2];
  assign periphIn.spiSelect = pin_sense_value[PB_SPI_SEL]; // RULE15
  assign periphIn.spiSlaveIn = pin_sense_value[PB_SPI_SLV_IN];
  assign periphIn.spiMasterIn = pin_sense_value[PB_SPI_MST_IN];
  assign periphIn.spiClockIn = pin_sense_value[PB_SPI_CLK];
  assign periphIn.twClockIn = pin_sense_value[PC_BASE+PC_TW_CLK];
  assign periphIn.twDataIn = pin_sense_value[PC_BASE+PC_TW_DATA];
  assign periphIn.scanClockIn = pin_sense_value[PC_BASE+PC_SCAN_CLK]; // RULE7
  assign periphIn.scanModeIn = pin_sense_value[PC_BASE+PC_SCAN_MODE]; // RULE6
  assign periphIn.scanDataIn = pin_sense_value[PC_BASE+PC_SCAN_DIN]; // RULE4
  assign periphIn.pinchgSource = pin_sense_value; // RULE8

  // Analog taps bypass the synchroniser; they are wires in the real pad
  assign analog_path.xtalPinOut = padInC[PC_XTAL_OUT]; // RULE11
  assign analog_path.xtalPinIn = padInC[PC_XTAL_IN];
  assign analog_path.scanDataIn = padInC[PC_SCAN_DIN];
  assign analog_path.scanModeIn = padInC[PC_SCAN_MODE];
  assign analog_path.scanClockIn = padInC[PC_SCAN_CLK];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Four steady samples fill the synchroniser; the port must still be enabled when the level lands
  sequence sHeldC5;
    (scan_port_enable && $stable(padInC[PC_SCAN_DIN]))[*4] ##1 scan_port_enable;
  endsequence

  a_scan_din_route: assert property (sHeldC5 |-> // RULE4
    periphIn.scanDataIn == $past(padInC[PC_SCAN_DIN])) else $error("scan data input not routed");
  a_scan_dout_drive: assert property (scan_port_enable |-> // RULE5
    (padC.padOen_n[PC_SCAN_DOUT] == !scanShift) && padC.pullEn[PC_SCAN_DOUT]) else $error("scan output pin wrong");
  a_xtal_out_release: assert property (timer2_async_sel && ext_osc_clock_sel |-> // RULE2
    padC.padOen_n[PC_XTAL_OUT] && !padC.pullEn[PC_XTAL_OUT] && padC.inbufEn[PC_XTAL_OUT]) else $error("c7 not released");
  a_xtal_in_release: assert property (timer2_async_sel |-> // RULE3
    padC.padOen_n[PC_XTAL_IN] && !padC.pullEn[PC_XTAL_IN] && padC.inbufEn[PC_XTAL_IN]) else $error("c6 not released");
  a_scan_inputs: assert property (scan_port_enable |-> // RULE6
    &padC.pullEn[PC_SCAN_MODE:PC_SCAN_CLK] && &padC.padOen_n[PC_SCAN_MODE:PC_SCAN_CLK]
    && &padC.inbufEn[PC_SCAN_MODE:PC_SCAN_CLK]) else $error("scan inputs not forced");
  a_scan_clk_route: assert property ((scan_port_enable && $stable(padInC[PC_SCAN_CLK]))[*4] ##1 // RULE7
    scan_port_enable |-> periphIn.scanClockIn == $past(padInC[PC_SCAN_CLK])) else $error("scan clock not routed");
  a_pinchg_buffer: assert property (pinchg_group2_en |-> // RULE8
    ((pinchgMask[PIN_CNT-1:PC_BASE] & ~padC.inbufEn) == SYNC_RST)) else $error("pin change buffer off");
  a_tw_data_pin: assert property (two_wire_enable |-> padC.padOen_n[PC_TW_DATA] // RULE9
    && padC.padOut[PC_TW_DATA] == twDataOut
    && padC.pullEn[PC_TW_DATA] == (latchC[PC_TW_DATA] && !global_pull_off)) else $error("sda pin wrong");
  a_tw_clk_pin: assert property (two_wire_enable |-> padC.padOen_n[PC_TW_CLK] // RULE10
    && padC.padOut[PC_TW_CLK] == twClockOut
    && padC.pullEn[PC_TW_CLK] == (latchC[PC_TW_CLK] && !global_pull_off)) else $error("scl pin wrong");
  a_clk_out_pin: assert property (sysclk_out_fuse |-> // RULE12
    !padB.padOen_n[PB_CLK_OUT] && padB.padOut[PB_CLK_OUT] == ioClkLevel) else $error("clock out not driven");
  a_cmp0a_value: assert property (cmp0a_drive_en |-> padB.padOut[PB_CMP0A] == cmp0a_wave // RULE13
    && padB.padOen_n[PB_CMP0A] == !dirRegB[PB_CMP0A]) else $error("compare 0a value wrong");
  a_irq2_buffer: assert property ((extIrq2Enable && $stable(padInB[PB_IRQ2]))[*4] ##1 // RULE14
    extIrq2Enable |-> periphIn.extIrq2Pin == $past(padInB[PB_IRQ2])) else $error("irq2 input lost");
  a_spi_slave_dir: assert property (spiSlave |-> padB.padOen_n[PB_SPI_SEL] && padB.padOen_n[PB_SPI_CLK] // RULE16
    && padB.padOen_n[PB_SPI_SLV_IN] && padB.pullEn[PB_SPI_CLK] == (latchB[PB_SPI_CLK] && !global_pull_off))
    else $error("spi slave pins not inputs");
  a_normal_path: assert property (!two_wire_enable |-> // RULE1
    padC.padOut[PC_TW_DATA] == latchC[PC_TW_DATA] && padC.padOen_n[PC_TW_DATA] == !dirRegC[PC_TW_DATA])
    else $error("normal port path not used");

endmodule : pao_port_override

// ==== pkg/pao_pkg.sv ====
package pao_pkg;

  // Pin positions on port B
  localparam int PB_CNT0_CLK = 0;
  localparam int PB_CLK_OUT = 1;
  localparam int PB_IRQ2 = 2;
  localparam int PB_CMP0A = 3;
  localparam int PB_SPI_SEL = 4;
  localparam int PB_SPI_SLV_IN = 5;
  localparam int PB_SPI_MST_IN = 6;
  localparam int PB_SPI_CLK = 7;

  // Pin positions on port C
  localparam int PC_TW_CLK = 0;
  localparam int PC_TW_DATA = 1;
  localparam int PC_SCAN_CLK = 2;
  localparam int PC_SCAN_MODE = 3;
  localparam int PC_SCAN_DOUT = 4;
  localparam int PC_SCAN_DIN = 5;
  localparam int PC_XTAL_IN = 6;
  localparam int PC_XTAL_OUT = 7;

  localparam int PORT_W = 8;
  localparam int PIN_CNT = 16;
  localparam int PC_BASE = 8;

  localparam logic [PORT_W-1:0] SYNC_RST = 8'h00;

  // Override signals of one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic inbuf_override_en;
    logic inbuf_override_val;
  } pao_ovr_s;

  // Pad controls of one port
  typedef struct packed {
    logic [PORT_W-1:0] padOut;
    logic [PORT_W-1:0] padOen_n;
    logic [PORT_W-1:0] pullEn;
    logic [PORT_W-1:0] inbufEn;
  } pao_pad_s;

  // Inputs routed from the pins to peripherals
  typedef struct packed {
    logic counter0ExtClock;
    logic counter1ExtClock;
    logic extIrq2Pin;
    logic spiSelect;
    logic spiSlaveIn;
    logic spiMasterIn;
    logic spiClockIn;
    logic twClockIn;
    logic twDataIn;
    logic scanClockIn;
    logic scanModeIn;
    logic scanDataIn;
    logic [PIN_CNT-1:0] pinchgSource;
  } pao_periph_s;

  // Analog taps on port C
  typedef struct packed {
    logic xtalPinOut;
    logic xtalPinIn;
    logic scanDataIn;
    logic scanModeIn;
    logic scanClockIn;
  } pao_analog_s;

  // Synchroniser state, index 0..7 port B, 8..15 port C
  typedef struct packed {
    logic [PIN_CNT-1:0] sync1;
    logic [PIN_CNT-1:0] sync2;
    logic [PIN_CNT-1:0] sync3;
    logic [PIN_CNT-1:0] settled;
  } pao_state_s;

endpackage : pao_pkg

// ==== testbench/pao_board_model.sv ====
`timescale 1ns/1ns
module pao_board_model
  import pao_pkg::*;
(
  // Pad controls from the block
  input wire pao_pad_s padB,
  input wire pao_pad_s padC,
  // Levels the board would drive on undriven pins
  input wire logic [PORT_W-1:0] extB,
  input wire logic [PORT_W-1:0] extC,
  // Resolved pad levels
  output logic [PORT_W-1:0] padInB,
  output logic [PORT_W-1:0] padInC
);
  // Driven pin wins; a pulled pin reads high, else the board level decides
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      padInB[i] = !padB.padOen_n[i] ? padB.padOut[i] : (padB.pullEn[i] ? 1'b1 : extB[i]);
      padInC[i] = !padC.padOen_n[i] ? padC.padOut[i] : (padC.pullEn[i] ? 1'b1 : extC[i]);
    end
  end
endmodule : pao_board_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
  import pao_pkg::*;
  logic ref_clk, reset_n, global_pull_off, sleepInputOff, timer2_async_sel, ext_osc_clock_sel;
  logic sysclk_out_fuse, ioClkLevel, scan_port_enable, scan_shift_instr, scan_shift_datareg, scanDataOut;
  logic two_wire_enable, twDataOut, twClockOut, cmp0a_drive_en, cmp0a_wave, spiEnable, spiMaster;
  logic extIrq2Enable, pinchg_group1_en, pinchg_group2_en;
  logic [PORT_W-1:0] latchB, latchC, dirRegB, dirRegC, extB, extC, padInB, padInC;
  logic [PIN_CNT-1:0] pinchgMask;
  pao_pad_s padB, padC;
  pao_periph_s periphIn;
  pao_analog_s analog_path;
  int mismatches = 0;
  int nCompared = 0;

  pao_port_override pao_port_override_inst (.ref_clk(ref_clk), .reset_n(reset_n), .latchB(latchB),
    .latchC(latchC), .dirRegB(dirRegB), .dirRegC(dirRegC), .global_pull_off(global_pull_off),
    .sleepInputOff(sleepInputOff), .padInB(padInB), .padInC(padInC), .padB(padB), .padC(padC),
    .timer2_async_sel(timer2_async_sel), .ext_osc_clock_sel(ext_osc_clock_sel),
    .sysclk_out_fuse(sysclk_out_fuse), .ioClkLevel(ioClkLevel), .scan_port_enable(scan_port_enable),
    .scan_shift_instr(scan_shift_instr), .scan_shift_datareg(scan_shift_datareg), .scanDataOut(scanDataOut),
    .two_wire_enable(two_wire_enable), .twDataOut(twDataOut), .twClockOut(twClockOut),
    .cmp0a_drive_en(cmp0a_drive_en), .cmp0a_wave(cmp0a_wave), .spiEnable(spiEnable), .spiMaster(spiMaster),
    .extIrq2Enable(extIrq2Enable), .pinchg_group1_en(pinchg_group1_en), .pinchg_group2_en(pinchg_group2_en),
    .pinchgMask(pinchgMask), .periphIn(periphIn), .analog_path(analog_path));
  pao_board_model pao_board_model_inst (.padB(padB), .padC(padC), .extB(extB), .extC(extC),
    .padInB(padInB), .padInC(padInC));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Inputs move 1 ns after the rising edge so nothing races the clock
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic idle();
    {global_pull_off, sleepInputOff, timer2_async_sel, ext_osc_clock_sel, sysclk_out_fuse, ioClkLevel} = '0;
    {scan_port_enable, scan_shift_instr, scan_shift_datareg, scanDataOut, two_wire_enable, twDataOut} = '0;
    {twClockOut, cmp0a_drive_en, cmp0a_wave, spiEnable, spiMaster, extIrq2Enable} = '0;
    {pinchg_group1_en, pinchg_group2_en, pinchgMask, latchB, latchC, dirRegB, dirRegC, extB, extC} = '0;
  endtask : idle

  task automatic t_normal();
    idle();
    latchC = 8'hA5; dirRegC = 8'h0F; latchB = 8'h3C; dirRegB = 8'hF0;
    step(1);
    check(padC.pullEn, 8'hA0, "normal pull C");
    check(padC.padOen_n, 8'hF0, "normal dir C");
    check(padC.padOut, 8'hA5, "normal out C");
    check(padB.pullEn, 8'h0C, "normal pull B");
    global_pull_off = 1'b1; sleepInputOff = 1'b1;
    step(1);
    check({padB.pullEn, padC.inbufEn}, 16'h0000, "pull and buffer off");
  endtask : t_normal

  task automatic t_twowire();
    idle();
    two_wire_enable = 1'b1; latchC = 8'h03; dirRegC = 8'h03; twDataOut = 1'b1;
    step(1);
    check({padC.padOen_n[1:0], padC.padOut[1:0], padC.pullEn[1:0]}, 16'h003B, "two-wire pins");
    global_pull_off = 1'b1;
    step(1);
    check(padC.pullEn[1:0], 16'h0000, "two-wire pull gated");
  endtask : t_twowire

  task automatic t_scan();
    idle();
    scan_port_enable = 1'b1; dirRegC = 8'hFF; global_pull_off = 1'b1; sleepInputOff = 1'b1; scanDataOut = 1'b1;
    step(1);
    check(padC.pullEn & 8'h3C, 8'h3C, "scan pulls on");
    check(padC.padOen_n & 8'h3C, 8'h3C, "scan pins input");
    check(padC.inbufEn & 8'h3C, 8'h3C, "scan buffers on");
    check(padC.padOut[4], 1'b1, "scan data out value");
    scan_shift_datareg = 1'b1;
    step(1);
    check(padC.padOen_n[4], 1'b0, "drives while data shift");
    {scan_shift_datareg, scan_shift_instr, scanDataOut} = 3'b010;
    step(1);
    check({padC.padOen_n[4], padC.padOut[4]}, 2'b00, "drives while instr shift");
    step(5);
    check({periphIn.scanDataIn, periphIn.scanModeIn, periphIn.scanClockIn}, 3'b111, "scan inputs routed");
  endtask : t_scan

  task automatic t_async();
    idle();
    timer2_async_sel = 1'b1; dirRegC = 8'hFF; latchC = 8'hFF; sleepInputOff = 1'b1;
    step(1);
    check({padC.pullEn[7:6], padC.padOen_n[7:6], padC.inbufEn[7:6]}, 6'b00_01_01, "async only");
    ext_osc_clock_sel = 1'b1;
    step(1);
    check({padC.pullEn[7:6], padC.padOen_n[7:6], padC.inbufEn[7:6]}, 6'b00_11_11, "async ext");
    timer2_async_sel = 1'b0;
    step(1);
    check({padC.padOen_n[7:6], padC.inbufEn[7:6]}, 4'b0000, "ext without async");
  endtask : t_async

  task automatic t_clkcmp();
    idle();
    sysclk_out_fuse = 1'b1; ioClkLevel = 1'b1; latchB = 8'h0F; cmp0a_drive_en = 1'b1;
    step(1);
    check({padB.padOen_n[1], padB.padOut[1], padB.padOut[3]}, 3'b010, "clock out and compare");
    check(padB.pullEn & 8'h0D, 8'h0D, "low B pulls from latch");
    ioClkLevel = 1'b0; cmp0a_wave = 1'b1;
    step(1);
    check({padB.padOut[1], padB.padOut[3]}, 2'b01, "clock low compare high");
  endtask : t_clkcmp

  task automatic t_spi();
    idle();
    spiEnable = 1'b1; dirRegB = 8'hFF; latchB = 8'hF0;
    step(1);
    check({padB.padOen_n[7:4], padB.pullEn[7:4]}, 8'hBB, "slave pins input");
    global_pull_off = 1'b1;
    step(1);
    check(padB.pullEn[7:4], 4'h0, "slave pulls gated");
    spiMaster = 1'b1;
    step(1);
    check(padB.padOen_n[7:4], 4'h4, "master input pin forced");
  endtask : t_spi

  task automatic t_route();
    idle();
    global_pull_off = 1'b1; extB = 8'hFF; extC = 8'hFF;
    step(1);
    check(analog_path, 5'h1F, "analog taps high");
    step(6);
    check({periphIn.counter0ExtClock, periphIn.counter1ExtClock, periphIn.extIrq2Pin, periphIn.spiSelect,
      periphIn.spiSlaveIn, periphIn.spiMasterIn, periphIn.spiClockIn, periphIn.twClockIn, periphIn.twDataIn,
      periphIn.scanClockIn, periphIn.scanModeIn, periphIn.scanDataIn}, 12'hFFF, "routed inputs");
    check(periphIn.pinchgSource, 16'hFFFF, "pin-change sources");
    extB = 8'h0C; extC = 8'h21; sleepInputOff = 1'b1; extIrq2Enable = 1'b1;
    pinchg_group1_en = 1'b1; pinchg_group2_en = 1'b1; pinchgMask = 16'h0108;
    step(1);
    check(analog_path, 5'b00100, "analog taps follow pads");
    step(6);
    check(periphIn.pinchgSource, 16'h010C, "forced buffers only");
    check(padB.inbufEn, 8'h0C, "port B buffers forced");
    check(periphIn.extIrq2Pin, 1'b1, "irq2 buffer forced");
  endtask : t_route

  initial begin
    idle();
    reset_n = 1'b0;
    step(4);
    reset_n = 1'b1;
    step(1);
    t_normal();
    t_twowire();
    t_scan();
    t_async();
    t_clkcmp();
    t_spi();
    t_route();
    tally_and_finish();
  end

  // The whole sequence takes well under 100 cycles
  initial begin
    #4000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb
